// file: rtl/uart_pkg.sv
// constants, types and register map of the serial port
package uart_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_ONE_LOW = 8'h8b;
  localparam logic [7:0] OFS_TIMER_ONE_HIGH = 8'h8d;
  localparam logic [7:0] OFS_BAUD_RELOAD = 8'h91;
  localparam logic [7:0] OFS_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] OFS_SERIAL_DATA = 8'h99;
  localparam logic [7:0] OFS_BAUD_CONTROL = 8'h9b;
  localparam logic [7:0] OFS_STATION_ADDRESS = 8'ha9;
  localparam logic [7:0] OFS_STATION_MASK = 8'hb9;
  localparam logic [7:0] OFS_POWER_CONTROL = 8'hc0;
  localparam logic [7:0] OFS_SERIAL_IO_CONFIG = 8'hc1;
  localparam logic [7:0] OFS_TIMER_ONE_CTRL = 8'hc2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // serial control
  localparam int SC_MODE_HIGH = 7;
  localparam int SC_MODE_LOW = 6;
  localparam int SC_ADDR_MATCH = 5;
  localparam int SC_RX_ENABLE = 4;
  localparam int SC_TX_NINTH = 3;
  localparam int SC_RX_NINTH = 2;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;
  // power control
  localparam int PC_BAUD_DOUBLE = 7;
  localparam int PC_FRAME_CHECK = 6;
  // baud control
  localparam int BC_RUN = 4;
  localparam int BC_TX_SOURCE = 3;
  localparam int BC_RX_SOURCE = 2;
  localparam int BC_SPEED = 1;
  localparam int BC_SYNC_SOURCE = 0;
  // serial io config
  localparam int IO_GATE_A = 0;
  localparam int IO_GATE_B = 1;
  // timer one control
  localparam int T1_RUN = 0;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [2:0] PRESCALE_LAST = 3'h5;   // divide by 6
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf; // 16 ticks per bit
  localparam logic [3:0] START_CHECK = 4'h7;     // centre of start bit
  localparam logic [3:0] FRAME_BITS_M1 = 4'ha;   // 10-bit frame
  localparam logic [3:0] FRAME_BITS_M23 = 4'hb;  // 11-bit frame
  localparam logic [3:0] RX_NINTH_INDEX = 4'h8;  // ninth receive bit
  localparam logic [2:0] SYNC_LAST_BIT = 3'h7;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MODE_SHIFT = 2'h0,
    MODE_UART8 = 2'h1,
    MODE_UART9_FIXED = 2'h2,
    MODE_UART9_VAR = 2'h3
  } port_mode_e;

  typedef enum logic [2:0]
  {
    TX_IDLE = 3'h1,
    TX_ASYNC = 3'h2,
    TX_SYNC = 3'h4
  } tx_state_e;

  typedef enum logic [2:0]
  {
    RX_IDLE = 3'h1,
    RX_START = 3'h2,
    RX_BITS = 3'h4
  } rx_state_e;

  // register bus request
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// file: rtl/serial_port_with_addr_match.sv
// serial port: shift-register mode, three uart modes, address match
`timescale 1ns/10ps

// Overview of operation
// - stop check only when frame check set
// - invalid stop bit sets frame error
// - frame error sticky until software or reset
// - with check, receive done at stop
// - given address compares only masked bits
// - broadcast address is address OR mask
// - reset clears address and mask
// - two mode bits select four modes
// - timer one only in modes 1, 3
// - timer one overflow, doubled by baud_double
// - generator reloads, prescale 1 or 6
// - generator runs on run bit, doubled
// - transmit and receive independent rates in modes 1, 3
// - mode 0 eight clocks, lsb first
// - each bit clock high then low
// - after eighth bit data high, done
// - txd and aux timer outputs gated by output enable input
// - mode 1 ten bits, stop in ninth
// - modes 2, 3 eleven bits, ninth bit
// - separate transmit and receive sources
module serial_port_with_addr_match
(
  input wire logic mclk,
  input wire logic rstn,
  input uart_pkg::reg_req_s req,
  output logic [7:0] rdata,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  output logic txd_oe,
  input wire logic out_enable_in,
  input wire logic aux_timer_in,
  output logic aux_timer_out,
  output logic aux_timer_oe
);
  import uart_pkg::*;

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0] tl1_reg, th1_reg, brl_reg, brg_cnt_reg; // counters/reloads
  logic [7:0] station_address_reg, station_address_mask_reg; // station address and mask
  logic [7:0] serial_data_buffer_rx_reg; // received byte
  logic [1:0] mode_reg; // port mode bits
  logic sm2_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg, fe_reg;
  logic baud_double_reg, frame_check_enable_reg; // power control bits
  logic [4:0] bdr_reg; // baud control bits
  logic [1:0] sio_reg; // output gate config
  logic t1_run_reg; // timer one run
  logic [2:0] t1_pre_reg, brg_pre_reg; // divide by 6 prescalers
  logic t1_half_reg, brg_half_reg; // halve overflow unless doubled
  logic [2:0] m0_pre_reg; // fixed mode 0 rate
  logic rxd_s1_reg, rxd_s2_reg, rxd_d_reg; // rxd synchroniser
  logic oe_s1_reg, oe_s2_reg; // output enable synchroniser
  tx_state_e tx_state_reg;
  rx_state_e rx_state_reg;
  logic [10:0] tx_sh_reg; // async transmit frame
  logic [3:0] tx_tick_reg, tx_bit_reg;
  logic [7:0] m0_sh_reg; // mode 0 shifter
  logic [2:0] m0_bit_reg;
  logic m0_phase_reg, m0_dir_rx_reg; // low half, receiving
  logic [8:0] rx_sh_reg;
  logic [3:0] rx_tick_reg, rx_bit_reg;
  logic [7:0] rdata_next;

  // decoded strobes
  logic wr_serial_control_reg, wr_serial_data_buffer;
  logic t1_ovf, brg_ovf, t1_tick, brg_tick, fixed_tick, m0_tick;
  logic tx_tick, rx_tick, nine_bit, frame_check;
  logic rx_deliver, rx_stop_done, rx_ok, fe_set, ti_set, ri_set;
  logic m0_rx_done, tx_async_done, m0_tx_done;
  logic [8:0] rx_sh_next, rx_word; // shifter next value, delivered word
  logic [3:0] frame_bits;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // register write decode
  function automatic logic hit(input reg_req_s r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  // oversampling tick: overflow halved unless rate doubled
  function automatic logic baud_tick(input logic ovf, input logic half,
                                     input logic dbl);
    baud_tick = ovf && (dbl || half);
  endfunction

  // ----------------------------------------------------------------
  // decode and selects
  // ----------------------------------------------------------------
  assign wr_serial_control_reg = hit(req, OFS_SERIAL_CONTROL);
  assign wr_serial_data_buffer = hit(req, OFS_SERIAL_DATA);
  assign frame_check = frame_check_enable_reg;
  assign nine_bit = mode_reg[1];
  assign frame_bits = nine_bit ? FRAME_BITS_M23 : FRAME_BITS_M1;

  assign t1_ovf = t1_run_reg && (t1_pre_reg == PRESCALE_LAST) && (tl1_reg == 8'hff);
  assign brg_ovf = bdr_reg[BC_RUN] && (bdr_reg[BC_SPEED] || (brg_pre_reg == PRESCALE_LAST))
                   && (brg_cnt_reg == 8'hff);
  assign t1_tick = baud_tick(t1_ovf, t1_half_reg, baud_double_reg);
  assign brg_tick = baud_tick(brg_ovf, brg_half_reg, baud_double_reg);
  assign fixed_tick = (m0_pre_reg == PRESCALE_LAST);
  assign m0_tick = bdr_reg[BC_SYNC_SOURCE] ? brg_tick : fixed_tick;

  // per-direction tick select
  always_comb
  begin
    if (mode_reg == MODE_UART9_FIXED)
    begin
      // fixed 1/32 or 1/16 of the clock: tick every 2 or 1 clocks
      tx_tick = baud_double_reg || t1_half_reg;
      rx_tick = baud_double_reg || t1_half_reg;
    end
    else
    begin
      tx_tick = bdr_reg[BC_TX_SOURCE] ? brg_tick : t1_tick;
      rx_tick = bdr_reg[BC_RX_SOURCE] ? brg_tick : t1_tick;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // two flops per pin, third for edge detect
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      rxd_d_reg <= 1'b1;
      oe_s1_reg <= 1'b0;
      oe_s2_reg <= 1'b0;
    end
    else
    begin
      rxd_s1_reg <= rxd_in;
      rxd_s2_reg <= rxd_s1_reg;
      rxd_d_reg <= rxd_s2_reg;
      oe_s1_reg <= out_enable_in;
      oe_s2_reg <= oe_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // baud sources
  // ----------------------------------------------------------------
  // timer one: 8-bit auto reload at clock / 6
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      tl1_reg <= RESET_BYTE;
      t1_pre_reg <= 3'h0;
      t1_half_reg <= 1'b0;
    end
    else if (hit(req, OFS_TIMER_ONE_LOW))
      tl1_reg <= req.wdata;
    else
    begin
      // prescale and half toggle; half also paces mode 2
      t1_pre_reg <= (t1_pre_reg == PRESCALE_LAST) ? 3'h0 : t1_pre_reg + 3'h1;
      if (t1_ovf || (mode_reg == MODE_UART9_FIXED))
        t1_half_reg <= ~t1_half_reg;
      if (t1_ovf)
        tl1_reg <= th1_reg;
      else if (t1_run_reg && (t1_pre_reg == PRESCALE_LAST))
        tl1_reg <= tl1_reg + 8'h01;
    end
  end

  // internal generator
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      brg_cnt_reg <= RESET_BYTE;
      brg_pre_reg <= 3'h0;
      brg_half_reg <= 1'b0;
    end
    else if (!bdr_reg[BC_RUN])
    begin
      brg_cnt_reg <= brl_reg;
      brg_pre_reg <= 3'h0;
    end
    else
    begin
      brg_pre_reg <= (brg_pre_reg == PRESCALE_LAST) ? 3'h0 : brg_pre_reg + 3'h1;
      if (brg_ovf)
      begin
        brg_cnt_reg <= brl_reg;
        brg_half_reg <= ~brg_half_reg;
      end
      else if (bdr_reg[BC_SPEED] || (brg_pre_reg == PRESCALE_LAST))
        brg_cnt_reg <= brg_cnt_reg + 8'h01;
    end
  end

  // fixed mode 0 phase rate
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      m0_pre_reg <= 3'h0;
    else
      m0_pre_reg <= fixed_tick ? 3'h0 : m0_pre_reg + 3'h1;
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // plain control registers
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      th1_reg <= RESET_BYTE;
      brl_reg <= RESET_BYTE;
      station_address_reg <= RESET_BYTE;
      station_address_mask_reg <= RESET_BYTE;
      baud_double_reg <= 1'b0;
      frame_check_enable_reg <= 1'b0;
      bdr_reg <= 5'h00;
      sio_reg <= 2'h0;
      t1_run_reg <= 1'b0;
    end
    else if (req.wr)
    begin
      case (req.addr)
        OFS_TIMER_ONE_HIGH: th1_reg <= req.wdata;
        OFS_BAUD_RELOAD: brl_reg <= req.wdata;
        OFS_STATION_ADDRESS: station_address_reg <= req.wdata;
        OFS_STATION_MASK: station_address_mask_reg <= req.wdata;
        OFS_POWER_CONTROL:
        begin
          baud_double_reg <= req.wdata[PC_BAUD_DOUBLE];
          frame_check_enable_reg <= req.wdata[PC_FRAME_CHECK];
        end
        OFS_BAUD_CONTROL: bdr_reg <= req.wdata[4:0];
        OFS_SERIAL_IO_CONFIG: sio_reg <= req.wdata[1:0];
        OFS_TIMER_ONE_CTRL: t1_run_reg <= req.wdata[T1_RUN];
        default: t1_run_reg <= t1_run_reg;
      endcase
    end
  end

  // serial control bits and receive buffer; hardware set beats clear
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      mode_reg <= MODE_SHIFT;
      {sm2_reg, ren_reg, tb8_reg, rb8_reg} <= 4'h0;
      {ti_reg, ri_reg, fe_reg} <= 3'h0;
      serial_data_buffer_rx_reg <= RESET_BYTE;
    end
    else
    begin
      if (wr_serial_control_reg)
      begin
        // bit 7 is the frame error flag while checking is on
        if (!frame_check)
          mode_reg[1] <= req.wdata[SC_MODE_HIGH];
        mode_reg[0] <= req.wdata[SC_MODE_LOW];
        sm2_reg <= req.wdata[SC_ADDR_MATCH];
        ren_reg <= req.wdata[SC_RX_ENABLE];
        tb8_reg <= req.wdata[SC_TX_NINTH];
        rb8_reg <= req.wdata[SC_RX_NINTH];
      end
      ti_reg <= ti_set || (wr_serial_control_reg ? req.wdata[SC_TX_DONE] : ti_reg);
      ri_reg <= ri_set || (wr_serial_control_reg ? req.wdata[SC_RX_DONE] : ri_reg);
      fe_reg <= fe_set || ((wr_serial_control_reg && frame_check) ? req.wdata[SC_MODE_HIGH] : fe_reg);
      if (m0_rx_done)
        serial_data_buffer_rx_reg <= {rxd_s2_reg, m0_sh_reg[7:1]};
      else if (rx_deliver && rx_ok)
      begin
        serial_data_buffer_rx_reg <= rx_word[7:0];
        rb8_reg <= rx_word[8];
      end
    end
  end

  // registered read data
  always_comb
  begin
    case (req.addr)
      OFS_TIMER_ONE_LOW: rdata_next = tl1_reg;
      OFS_TIMER_ONE_HIGH: rdata_next = th1_reg;
      OFS_BAUD_RELOAD: rdata_next = brl_reg;
      OFS_SERIAL_CONTROL: rdata_next = {frame_check ? fe_reg : mode_reg[1], mode_reg[0],
                                        sm2_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg};
      OFS_SERIAL_DATA: rdata_next = serial_data_buffer_rx_reg;
      OFS_BAUD_CONTROL: rdata_next = {3'h0, bdr_reg};
      OFS_STATION_ADDRESS: rdata_next = station_address_reg;
      OFS_STATION_MASK: rdata_next = station_address_mask_reg;
      OFS_POWER_CONTROL: rdata_next = {baud_double_reg, frame_check_enable_reg, 6'h00};
      OFS_SERIAL_IO_CONFIG: rdata_next = {6'h00, sio_reg};
      OFS_TIMER_ONE_CTRL: rdata_next = {7'h00, t1_run_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (req.rd)
      rdata <= rdata_next;
  end

  // ----------------------------------------------------------------
  // transmitter and mode 0 engine
  // ----------------------------------------------------------------
  assign tx_async_done = (tx_state_reg == TX_ASYNC) && tx_tick
                         && (tx_tick_reg == OVERSAMPLE_LAST) && (tx_bit_reg == frame_bits - 4'h1);
  assign m0_tx_done = (tx_state_reg == TX_SYNC) && m0_tick && m0_phase_reg
                      && (m0_bit_reg == SYNC_LAST_BIT);
  assign m0_rx_done = m0_tx_done && m0_dir_rx_reg;
  assign ti_set = (m0_tx_done && !m0_dir_rx_reg) || tx_async_done;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg <= 11'h7ff;
      {tx_tick_reg, tx_bit_reg} <= 8'h00;
      m0_sh_reg <= RESET_BYTE;
      m0_bit_reg <= 3'h0;
      m0_phase_reg <= 1'b0;
      m0_dir_rx_reg <= 1'b0;
    end
    else
    begin
      case (tx_state_reg)
        TX_IDLE:
        begin
          if (wr_serial_data_buffer && (mode_reg == MODE_SHIFT))
          begin
            m0_sh_reg <= req.wdata;
            {m0_bit_reg, m0_phase_reg, m0_dir_rx_reg} <= 5'h00;
            tx_state_reg <= TX_SYNC;
          end
          else if (wr_serial_control_reg && (req.wdata[7:6] == 2'h0) && req.wdata[SC_RX_ENABLE]
                   && !req.wdata[SC_RX_DONE] && !frame_check)
          begin
            {m0_bit_reg, m0_phase_reg} <= 4'h0;
            m0_dir_rx_reg <= 1'b1;
            tx_state_reg <= TX_SYNC;
          end
          else if (wr_serial_data_buffer)
          begin
            // stop, ninth or stop, data, start
            tx_sh_reg <= {1'b1, nine_bit ? tb8_reg : 1'b1, req.wdata, 1'b0};
            {tx_tick_reg, tx_bit_reg} <= 8'h00;
            tx_state_reg <= TX_ASYNC;
          end
        end
        TX_ASYNC:
        begin
          if (tx_tick)
          begin
            tx_tick_reg <= tx_tick_reg + 4'h1;
            if (tx_tick_reg == OVERSAMPLE_LAST)
            begin
              tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
              tx_bit_reg <= tx_bit_reg + 4'h1;
              if (tx_async_done)
                tx_state_reg <= TX_IDLE;
            end
          end
        end
        TX_SYNC:
        begin
          if (m0_tick)
          begin
            m0_phase_reg <= ~m0_phase_reg;
            if (m0_phase_reg)
            begin
              m0_sh_reg <= {m0_dir_rx_reg ? rxd_s2_reg : 1'b1, m0_sh_reg[7:1]};
              m0_bit_reg <= m0_bit_reg + 3'h1;
              if (m0_bit_reg == SYNC_LAST_BIT)
                tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // pin drive
  always_comb
  begin
    txd_oe = !sio_reg[IO_GATE_A] || oe_s2_reg;
    aux_timer_oe = !sio_reg[IO_GATE_B] || oe_s2_reg;
    aux_timer_out = aux_timer_in;
    if (mode_reg == MODE_SHIFT)
    begin
      txd_out = (tx_state_reg == TX_SYNC) ? !m0_phase_reg : 1'b1;
      rxd_oe = !((tx_state_reg == TX_SYNC) && m0_dir_rx_reg);
      rxd_out = (tx_state_reg == TX_SYNC) ? m0_sh_reg[0] : 1'b1;
    end
    else
    begin
      txd_out = (tx_state_reg == TX_ASYNC) ? tx_sh_reg[0] : 1'b1;
      rxd_oe = 1'b0;
      rxd_out = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // asynchronous receiver
  // ----------------------------------------------------------------
  assign rx_sh_next = {rxd_s2_reg, rx_sh_reg[8:1]};
  // delivered at the stop sample, the shifter already holds data and ninth bit
  assign rx_word = (frame_check && nine_bit) ? rx_sh_reg : rx_sh_next;
  // delivery at ninth bit, or at stop when checking
  assign rx_deliver = (rx_state_reg == RX_BITS) && rx_tick && (rx_tick_reg == OVERSAMPLE_LAST)
                      && (rx_bit_reg == ((frame_check && nine_bit) ? RX_NINTH_INDEX + 4'h1
                                                                  : RX_NINTH_INDEX));
  // stop sample: mode 1 ninth bit, modes 2, 3 the bit after
  assign rx_stop_done = (rx_state_reg == RX_BITS) && rx_tick && (rx_tick_reg == OVERSAMPLE_LAST)
                        && (rx_bit_reg == (nine_bit ? RX_NINTH_INDEX + 4'h1 : RX_NINTH_INDEX));
  assign fe_set = frame_check && rx_stop_done && !rxd_s2_reg;
  assign ri_set = m0_rx_done || (rx_deliver && rx_ok);

  // acceptance with address recognition
  always_comb
  begin
    logic [7:0] a;
    logic [7:0] bcast;
    logic given_hit, bcast_hit;
    a = rx_word[7:0];
    given_hit = ((a ^ station_address_reg) & station_address_mask_reg) == 8'h00;
    bcast = station_address_reg | station_address_mask_reg;
    bcast_hit = ((a ^ bcast) & bcast) == 8'h00;
    if (ri_reg)
      rx_ok = 1'b0;
    else if (!sm2_reg)
      rx_ok = 1'b1;
    else if (nine_bit)
      rx_ok = rx_word[8] && (given_hit || bcast_hit);
    else
      rx_ok = rx_word[8];
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rx_state_reg <= RX_IDLE;
      rx_sh_reg <= 9'h000;
      {rx_tick_reg, rx_bit_reg} <= 8'h00;
    end
    else
    begin
      case (rx_state_reg)
        RX_IDLE:
        begin
          if (ren_reg && (mode_reg != MODE_SHIFT) && rxd_d_reg && !rxd_s2_reg)
          begin
            {rx_tick_reg, rx_bit_reg} <= 8'h00;
            rx_state_reg <= RX_START;
          end
        end
        RX_START:
        begin
          if (rx_tick)
          begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == START_CHECK)
            begin
              rx_tick_reg <= 4'h0;
              rx_state_reg <= rxd_s2_reg ? RX_IDLE : RX_BITS;
            end
          end
        end
        RX_BITS:
        begin
          if (rx_tick)
          begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == OVERSAMPLE_LAST)
            begin
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg <= RX_NINTH_INDEX)
                rx_sh_reg <= rx_sh_next;
              if (rx_stop_done)
                rx_state_reg <= RX_IDLE;
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

endmodule // serial_port_with_addr_match

// file: tb/serial_port_monitor.sv
// checker of the serial port pins
`timescale 1ns/10ps
module serial_port_monitor
(
  input wire logic mclk,
  input wire logic rstn,
  input uart_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic out_enable_in,
  input wire logic aux_timer_in,
  input wire logic aux_timer_out,
  input wire logic aux_timer_oe
);
  import uart_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // low half of a mode 0 bit lasts one six-clock phase
  sequence low_half;
    !txd_out [*6] ##1 txd_out;
  endsequence
  AST_RESET_IDLE:
    assert property (disable iff (1'b0) !rstn |=> txd_out && rxd_out && rdata == 8'h00)
    else $error("pins not idle after reset");
  AST_RDATA_HOLD:
    assert property (!req.rd |=> $stable(rdata)) else $error("read data moved without read");
  AST_M0_LOW_HALF:
    assert property ($fell(txd_out) && rxd_oe |-> low_half) else $error("bad mode 0 low half");
  AST_M0_DATA_EDGE:
    assert property (rxd_oe && $past(rxd_oe) && $changed(rxd_out)
                     |-> $rose(txd_out) || $past(req.wr))
    else $error("data pin moved off the clock rise");
  AST_AUX_PASS:
    assert property (aux_timer_out == aux_timer_in) else $error("aux output not passed");
  AST_GATE_OPEN:
    assert property (out_enable_in [*3] |=> txd_oe && aux_timer_oe)
    else $error("outputs gated while enabled");
  AST_TXOE_FELL:
    assert property ($fell(txd_oe) |-> !$past(out_enable_in, 2)) else $error("tx gate fell");
  AST_AUXOE_FELL:
    assert property ($fell(aux_timer_oe) |-> !$past(out_enable_in, 2)) else $error("aux gate fell");
endmodule // serial_port_monitor

// file: tb/uart_peer_model.sv
// remote serial transmitter driving the receive line
`timescale 1ns/10ps
module uart_peer_model
#(
  parameter int BIT_CLOCKS = 16
)
(
  input wire logic mclk,
  input wire logic go,
  input wire logic [10:0] frame,
  input wire logic [3:0] nbits,
  output logic line
);
  logic [10:0] shift_reg = 11'h7ff;
  int bits_left = 0;
  int clk_cnt = 0;
  always @(posedge mclk)
  begin
    if (go)
    begin
      shift_reg <= frame;
      bits_left <= int'(nbits);
      clk_cnt <= 0;
    end
    else if (bits_left > 0)
    begin
      clk_cnt <= (clk_cnt == BIT_CLOCKS - 1) ? 0 : clk_cnt + 1;
      if (clk_cnt == BIT_CLOCKS - 1)
      begin
        shift_reg <= shift_reg >> 1;
        bits_left <= bits_left - 1;
      end
    end
  end
  // released line rests high on its pull-up
  assign line = (bits_left > 0) ? shift_reg[0] : 1'b1;
endmodule // uart_peer_model

// file: tb/tb_top.sv
// self-checking bench of the serial port
`timescale 1ns/10ps
module tb_top;
  import uart_pkg::*;
  logic mclk, rstn, rxd_out, rxd_oe, txd_out, txd_oe, peer_go, peer_line;
  logic out_enable_in, aux_timer_in, aux_timer_out, aux_timer_oe;
  reg_req_s req;
  logic [7:0] rdata;
  logic [10:0] peer_frame;
  logic [3:0] peer_bits;
  wire logic rxd_in = rxd_oe ? rxd_out : peer_line;
  int failures = 0;
  int checked = 0;
  // given 0101 01xx, broadcast 1111 111x
  logic [7:0] addr_tab [4] = '{8'h57, 8'h66, 8'hff, 8'h55};
  logic take_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  // mode 3 frame of 96h with ninth bit clear: stop, ninth, data, start
  logic [10:0] tx_frame = {1'b1, 1'b0, 8'h96, 1'b0};
  serial_port_with_addr_match uut (.mclk, .rstn, .req, .rdata, .rxd_in, .rxd_out, .rxd_oe,
    .txd_out, .txd_oe, .out_enable_in, .aux_timer_in, .aux_timer_out, .aux_timer_oe);
  uart_peer_model peer (.mclk, .go(peer_go), .frame(peer_frame), .nbits(peer_bits),
    .line(peer_line));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req <= '0;
    @(negedge mclk);
    check("register", rdata & msk, exp & msk);
    @(posedge mclk);
  endtask
  task automatic wait_txd(input logic lvl);
    int n;
    n = 0;
    while (txd_out !== lvl && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 200)
    begin
      failures++;
      finish_test();
    end
  endtask
  task automatic send(input logic [10:0] f, input logic [3:0] b);
    peer_frame <= f;
    peer_bits <= b;
    peer_go <= 1'b1;
    @(posedge mclk);
    peer_go <= 1'b0;
    repeat (int'(b) * 16 + 40) @(posedge mclk);
  endtask
  initial
  begin
    rstn = 1'b0;
    req = '0;
    out_enable_in = 1'b1;
    aux_timer_in = 1'b0;
    peer_go = 1'b0;
    peer_frame = '1;
    peer_bits = 4'h0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    reg_rd(OFS_STATION_ADDRESS, 8'h00, 8'hff);
    reg_rd(OFS_STATION_MASK, 8'h00, 8'hff);
    reg_wr(8'h00, 8'h5a);
    reg_rd(8'h00, 8'h00, 8'hff);
    $display("test reset done");
    reg_wr(OFS_SERIAL_CONTROL, 8'h00);
    reg_wr(OFS_SERIAL_DATA, 8'ha5);
    for (int i = 0; i < 8; i++)
    begin
      wait_txd(1'b0);
      check("data pin", {7'h00, rxd_out}, (8'ha5 >> i) & 8'h01);
      wait_txd(1'b1);
    end
    @(negedge mclk);
    check("data pin end", {7'h00, rxd_out}, 8'h01);
    @(posedge mclk);
    reg_rd(OFS_SERIAL_CONTROL, 8'h02, 8'hff);
    $display("test shift transmit done");
    reg_wr(OFS_SERIAL_CONTROL, 8'h10);
    send(11'h000, 4'h8);
    reg_rd(OFS_SERIAL_CONTROL, 8'h01, 8'h03);
    reg_rd(OFS_SERIAL_DATA, 8'h00, 8'hff);
    $display("test shift receive done");
    reg_wr(OFS_SERIAL_IO_CONFIG, 8'h03);
    out_enable_in <= 1'b0;
    aux_timer_in <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check("gates", {5'h00, txd_oe, aux_timer_oe, aux_timer_out}, 8'h01);
    @(posedge mclk);
    out_enable_in <= 1'b1;
    $display("test output gate done");
    reg_wr(OFS_BAUD_RELOAD, 8'hff);
    reg_wr(OFS_BAUD_CONTROL, 8'h1e);
    reg_wr(OFS_SERIAL_CONTROL, 8'h50);
    reg_wr(OFS_POWER_CONTROL, 8'hc0);
    send({2'b00, 8'h3c, 1'b0}, 4'ha);
    reg_rd(OFS_SERIAL_CONTROL, 8'hd1, 8'hff);
    reg_rd(OFS_SERIAL_DATA, 8'h3c, 8'hff);
    reg_wr(OFS_SERIAL_CONTROL, 8'hd0);
    send({2'b01, 8'h81, 1'b0}, 4'ha);
    reg_rd(OFS_SERIAL_CONTROL, 8'hd5, 8'hff);
    reg_rd(OFS_SERIAL_DATA, 8'h81, 8'hff);
    reg_wr(OFS_SERIAL_CONTROL, 8'h50);
    reg_rd(OFS_SERIAL_CONTROL, 8'h50, 8'hfb);
    $display("test frame error done");
    reg_wr(OFS_POWER_CONTROL, 8'h80);
    reg_wr(OFS_SERIAL_CONTROL, 8'hf0);
    reg_wr(OFS_STATION_ADDRESS, 8'h56);
    reg_wr(OFS_STATION_MASK, 8'hfc);
    reg_rd(OFS_STATION_MASK, 8'hfc, 8'hff);
    foreach (addr_tab[i])
    begin
      send({2'b11, addr_tab[i], 1'b0}, 4'hb);
      reg_rd(OFS_SERIAL_CONTROL, {7'h00, take_tab[i]}, 8'h01);
      reg_wr(OFS_SERIAL_CONTROL, 8'hf0);
    end
    $display("test address match done");
    reg_wr(OFS_SERIAL_DATA, 8'h96);
    wait_txd(1'b0);
    for (int i = 0; i < 11; i++)
    begin
      repeat (8) @(negedge mclk);
      check("tx bit", {7'h00, txd_out}, {7'h00, tx_frame[i]});
      repeat (8) @(negedge mclk);
    end
    @(posedge mclk);
    reg_rd(OFS_SERIAL_CONTROL, 8'h02, 8'h02);
    $display("test async transmit done");
    finish_test();
  end
endmodule // tb_top
bind serial_port_with_addr_match serial_port_monitor mon (.mclk, .rstn, .req, .rdata, .rxd_out,
  .rxd_oe, .txd_out, .txd_oe, .out_enable_in, .aux_timer_in, .aux_timer_out, .aux_timer_oe);
